//--- lcf_pkg.sv
// package of constants and types for the logic, pad and clock fabric block
package lcf_pkg;

    // ==========================================================
    // register bus
    localparam int         ADDR_W         = 8;
    localparam int         DATA_W         = 32;
    localparam logic [7:0] OFS_LOGIC_CFG  = 8'h00;
    localparam logic [7:0] OFS_PAD_CFG    = 8'h04;
    localparam logic [7:0] OFS_NET_CFG    = 8'h08;
    localparam logic [7:0] OFS_ROLE_CFG   = 8'h0C;
    localparam logic [7:0] OFS_STATUS     = 8'h10;

    // ==========================================================
    // clock network ratings, sampling clock and diagnostic shift width
    localparam int REF_CLK_MHZ        = 125;
    localparam int HARD_NET_MAX_MHZ   = 200;
    localparam int ROUTED_NET_MAX_MHZ = 150;
    localparam int DIAG_SHIFT_W       = 8;

    // ==========================================================
    // enumerations
    typedef enum logic [1:0] {
        SCLK_ROUTED0,
        SCLK_ROUTED1,
        SCLK_ARRAY,
        SCLK_ARRAY_ALT
    } lcf_sclk_sel_t;

    typedef enum logic [1:0] {
        SRC_PAD_A,
        SRC_PAD_B,
        SRC_INT_A,
        SRC_INT_B
    } lcf_net_src_t;

    // ==========================================================
    // carriers and register layouts
    typedef struct packed {
        logic [3:0] data;
        logic       and_term_first;
        logic       and_term_second;
        logic       or_term_first;
        logic       or_term_second;
    } lcf_cmod_in_t;

    typedef struct packed {
        lcf_sclk_sel_t clk_sel;
        logic          latch_mode;
    } lcf_logic_cfg_t;

    typedef struct packed {
        logic track_test;
        logic lower_chan;
        logic side_module;
        logic y_feedback;
        logic preset_sel;
        logic out_bypass;
        logic in_bypass;
    } lcf_pad_cfg_t;

    typedef struct packed {
        lcf_net_src_t src1;
        lcf_net_src_t src0;
    } lcf_net_cfg_t;

    typedef struct packed {
        logic lock;
        logic pcl_special;
        logic dedicated_pad_register_clock_special;
        logic hclk_special;
        logic external_clock_pad_b_special;
        logic external_clock_pad_a_special;
    } lcf_role_cfg_t;

    typedef struct packed {
        logic [DIAG_SHIFT_W-1:0] diag_shift;
        logic                    in_reg;
        logic                    out_reg;
        logic                    sm_q;
    } lcf_status_t;

    typedef struct packed {
        logic data;
        logic oe_n;
        logic recv_en;
        logic slew;
    } lcf_pad_drv_t;

    localparam lcf_logic_cfg_t LOGIC_CFG_RST = '0;
    localparam lcf_pad_cfg_t   PAD_CFG_RST   = '0;
    localparam lcf_net_cfg_t   NET_CFG_RST   = '0;
    localparam lcf_role_cfg_t  ROLE_CFG_RST  = '0;
    localparam int LOGIC_CFG_W = $bits(lcf_logic_cfg_t);
    localparam int PAD_CFG_W   = $bits(lcf_pad_cfg_t);
    localparam int NET_CFG_W   = $bits(lcf_net_cfg_t);
    localparam int ROLE_CFG_W  = $bits(lcf_role_cfg_t);

endpackage

//--- lcf_fabric.sv
// logic, pad and clock fabric primitives of an antifuse gate array
// Contract
// - combinational cell is a 4:1 mux, select0 = AND, select1 = OR
// - sequential cell feeds its own mux into a latch or flip-flop
// - clear from routing forces the stored bit to zero
// - sequential clock picks routed zero, routed one or dedicated array clock
// - pad cell has input and output register on the dedicated pad clock
// - each pad register may be bypassed for a combinational path
// - each pad register has its own load enable from routing
// - global set/reset net acts as preset or clear, chosen per pad cell
// - array output carries pad input or the fed back output register
// - side cells take upper or lower channel, top/bottom only one
// - pad driver is tri-state with enable, receive enable, data out, data in
// - in diagnostic mode global drive, receive and slew steer the pad
// - temporary special pins are user pins unless diagnostic mode is on
// - permanent pin roles are frozen once configuration is locked
// - four networks: two dedicated to 200 MHz, two routed to 150 MHz
// - dedicated nets go straight to array or pad registers, no selection
// - each routed net picks pad A, pad B, internal A or internal B
// - routed nets also carry high fanout non-clock signals
// - track pass switches stay off except in test mode
// - set/reset net reaches every pad register directly
// - diagnostic clock, serial input and probes special only in diag mode
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module lcf_fabric
    import lcf_pkg::*;
(
    input  wire logic              ref_clk,                      // sampling clock
    input  wire logic              nrst,                         // async reset, low
    input  wire logic [ADDR_W-1:0] reg_addr,                     // register address
    input  wire logic [DATA_W-1:0] reg_wdata,                    // write data
    input  wire logic              reg_wr,                       // write strobe
    input  wire logic              reg_rd,                       // read strobe
    output logic      [DATA_W-1:0] reg_rdata,                    // read data
    input  wire lcf_cmod_in_t      cm_in,                        // c-cell inputs
    input  wire lcf_cmod_in_t      sm_in,                        // s-cell mux inputs
    input  wire logic              storage_clear,                // s-cell clear
    output logic                   cm_y,                         // c-cell output
    output logic                   sm_q,                         // s-cell stored bit
    input  wire logic              external_clock_pad_a,         // clock pad a
    input  wire logic              external_clock_pad_b,         // clock pad b
    input  wire logic              internal_clock_source_a,      // internal source a
    input  wire logic              internal_clock_source_b,      // internal source b
    input  wire logic              hard_array_clock,             // dedicated array net
    input  wire logic              dedicated_pad_register_clock, // dedicated pad net
    input  wire logic              pad_register_set_reset_net,   // global set/reset
    output logic                   routed_clock_zero,            // routed net 0
    output logic                   routed_clock_one,             // routed net 1
    output logic [4:0]             perm_pin_user_in,             // permanent pins as i/o
    input  wire logic              upper_channel_input,          // channel above
    input  wire logic              lower_channel_input,          // channel below
    input  wire logic              output_register_load_enable,  // out reg enable
    input  wire logic              input_register_load_enable,   // in reg enable
    input  wire logic              pad_drive_request,            // user output enable
    input  wire logic              pad_receive_enable,           // user input enable
    input  wire logic              pad_in,                       // data from pad
    output lcf_pad_drv_t           pad_drv,                      // pad driver controls
    output logic                   pad_y,                        // pad cell to array
    input  wire logic              diag_mode,                    // diagnostic mode
    input  wire logic              global_pad_drive_enable,      // test drive enable
    input  wire logic              global_pad_receive_enable,    // test receive enable
    input  wire logic              slew_select,                  // per-pad slew
    input  wire logic              diagnostic_clock_pin,         // diag clock pin
    input  wire logic              serial_program_input,         // diag serial pin
    input  wire logic              user_probe_a,                 // user data, probe a
    input  wire logic              user_probe_b,                 // user data, probe b
    output logic                   probe_output_a,               // probe pin a
    output logic                   probe_output_b,               // probe pin b
    output logic [1:0]             diag_pin_user_in,             // diag pins as i/o
    output logic                   track_pass_on                 // track test switches
);

    // ==========================================================
    // shared decode
    // c-cell function used by both cells
    function automatic logic c_mux(input lcf_cmod_in_t c);
        logic [1:0] sel;
        sel = {c.or_term_first | c.or_term_second,
               c.and_term_first & c.and_term_second};
        return c.data[sel];
    endfunction

    // ==========================================================
    // configuration registers
    lcf_logic_cfg_t          logic_cfg_reg;
    lcf_pad_cfg_t            pad_cfg_reg;
    lcf_net_cfg_t            net_cfg_reg;
    lcf_role_cfg_t           role_cfg_reg;
    logic [DATA_W-1:0]       rdata_reg;
    logic                    cm_y_reg;
    logic                    sm_q_reg;
    logic                    sclk_prev_reg;
    logic                    dedicated_pad_register_clock_prev_reg;
    logic                    diagnostic_clock_pin_prev_reg;
    logic                    out_reg;
    logic                    in_reg;
    logic [1:0]              routed_reg;
    logic [4:0]              perm_user_reg;
    lcf_pad_drv_t            pad_drv_reg;
    logic                    pad_y_reg;
    logic                    probe_a_reg;
    logic                    probe_b_reg;
    logic [1:0]              diag_user_reg;
    logic                    track_pass_reg;
    logic [DIAG_SHIFT_W-1:0] diag_shift_reg;
    logic                    sclk_now;
    logic                    pad_a_eff;
    logic                    pad_b_eff;
    logic                    hclk_eff;
    logic                    dedicated_pad_register_clock_eff;
    logic                    pcl_eff;
    logic                    recv_eff;
    logic                    pad_in_gated;
    logic                    out_src;
    logic                    io_edge;
    logic                    s_edge;
    lcf_status_t             status;
    lcf_net_src_t            route_src [2];

    // software writes; role register freezes after lock
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            logic_cfg_reg <= LOGIC_CFG_RST;
            pad_cfg_reg   <= PAD_CFG_RST;
            net_cfg_reg   <= NET_CFG_RST;
            role_cfg_reg  <= ROLE_CFG_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_LOGIC_CFG: logic_cfg_reg <= lcf_logic_cfg_t'(reg_wdata[LOGIC_CFG_W-1:0]);
                OFS_PAD_CFG:   pad_cfg_reg   <= lcf_pad_cfg_t'(reg_wdata[PAD_CFG_W-1:0]);
                OFS_NET_CFG:   net_cfg_reg   <= lcf_net_cfg_t'(reg_wdata[NET_CFG_W-1:0]);
                OFS_ROLE_CFG: begin
                    if (!role_cfg_reg.lock) begin
                        role_cfg_reg <= lcf_role_cfg_t'(reg_wdata[ROLE_CFG_W-1:0]);
                    end
                end
                default: ;
            endcase
        end
    end

    // status view of the stored bits
    always_comb begin
        status            = '0;
        status.diag_shift = diag_shift_reg;
        status.in_reg     = in_reg;
        status.out_reg    = out_reg;
        status.sm_q       = sm_q_reg;
    end

    // read data valid only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_LOGIC_CFG: rdata_reg <= DATA_W'(logic_cfg_reg);
                OFS_PAD_CFG:   rdata_reg <= DATA_W'(pad_cfg_reg);
                OFS_NET_CFG:   rdata_reg <= DATA_W'(net_cfg_reg);
                OFS_ROLE_CFG:  rdata_reg <= DATA_W'(role_cfg_reg);
                OFS_STATUS:    rdata_reg <= DATA_W'(status);
                default:       rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    // ==========================================================
    // permanent special pins and clock networks
    // a pin set to normal role feeds no network
    assign pad_a_eff = external_clock_pad_a & role_cfg_reg.external_clock_pad_a_special;
    assign pad_b_eff = external_clock_pad_b & role_cfg_reg.external_clock_pad_b_special;
    assign hclk_eff  = hard_array_clock & role_cfg_reg.hclk_special;
    assign dedicated_pad_register_clock_eff = dedicated_pad_register_clock & role_cfg_reg.dedicated_pad_register_clock_special;
    assign pcl_eff   = pad_register_set_reset_net & role_cfg_reg.pcl_special;
    assign route_src[0] = net_cfg_reg.src0;
    assign route_src[1] = net_cfg_reg.src1;

    // permanent pins in normal role pass through as user inputs
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            perm_user_reg <= '0;
        end else begin
            perm_user_reg <= {pad_register_set_reset_net, dedicated_pad_register_clock,
                              hard_array_clock, external_clock_pad_b, external_clock_pad_a}
                             & ~{role_cfg_reg.pcl_special, role_cfg_reg.dedicated_pad_register_clock_special,
                                 role_cfg_reg.hclk_special, role_cfg_reg.external_clock_pad_b_special,
                                 role_cfg_reg.external_clock_pad_a_special};
        end
    end

    // two identical routed networks, each with its own source selector
    generate
        for (genvar i = 0; i < 2; i++) begin : g_routed
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    routed_reg[i] <= 1'b0;
                end else begin
                    case (route_src[i])
                        SRC_PAD_A: routed_reg[i] <= pad_a_eff;
                        SRC_PAD_B: routed_reg[i] <= pad_b_eff;
                        SRC_INT_A: routed_reg[i] <= internal_clock_source_a;
                        SRC_INT_B: routed_reg[i] <= internal_clock_source_b;
                        default:   routed_reg[i] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // ==========================================================
    // combinational and sequential logic cells
    // sequential cell clock selector
    always_comb begin
        case (logic_cfg_reg.clk_sel)
            SCLK_ROUTED0: sclk_now = routed_reg[0];
            SCLK_ROUTED1: sclk_now = routed_reg[1];
            default:      sclk_now = hclk_eff;
        endcase
    end
    assign s_edge = sclk_now & ~sclk_prev_reg;

    // c-cell output registered
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cm_y_reg <= 1'b0;
        end else begin
            cm_y_reg <= c_mux(cm_in);
        end
    end

    // storage element: clear wins, latch follows while clock high, ff on rise
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sm_q_reg      <= 1'b0;
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_now;
            if (storage_clear) begin
                sm_q_reg <= 1'b0;
            end else if (logic_cfg_reg.latch_mode ? sclk_now : s_edge) begin
                sm_q_reg <= c_mux(sm_in);
            end
        end
    end

    // ==========================================================
    // pad cell and pad driver
    assign recv_eff     = diag_mode ? global_pad_receive_enable : pad_receive_enable;
    assign pad_in_gated = pad_in & recv_eff;
    assign out_src      = (pad_cfg_reg.side_module && pad_cfg_reg.lower_chan)
                          ? lower_channel_input : upper_channel_input;
    assign io_edge      = dedicated_pad_register_clock_eff & ~dedicated_pad_register_clock_prev_reg;

    // pad registers: set/reset net overrides, enable gates the edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_reg        <= 1'b0;
            in_reg         <= 1'b0;
            dedicated_pad_register_clock_prev_reg <= 1'b0;
        end else begin
            dedicated_pad_register_clock_prev_reg <= dedicated_pad_register_clock_eff;
            if (pcl_eff) begin
                out_reg <= pad_cfg_reg.preset_sel;
                in_reg  <= pad_cfg_reg.preset_sel;
            end else if (io_edge) begin
                if (output_register_load_enable) begin
                    out_reg <= out_src;
                end
                if (input_register_load_enable) begin
                    in_reg <= pad_in_gated;
                end
            end
        end
    end

    // pad driver controls and array-side output
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pad_drv_reg <= '{data: 1'b0, oe_n: 1'b1, recv_en: 1'b0, slew: 1'b0};
            pad_y_reg   <= 1'b0;
        end else begin
            pad_drv_reg.data    <= pad_cfg_reg.out_bypass ? out_src : out_reg;
            pad_drv_reg.oe_n    <= ~(diag_mode ? global_pad_drive_enable
                                               : pad_drive_request);
            pad_drv_reg.recv_en <= recv_eff;
            pad_drv_reg.slew    <= diag_mode & slew_select;
            if (pad_cfg_reg.y_feedback) begin
                pad_y_reg <= out_reg;
            end else begin
                pad_y_reg <= pad_cfg_reg.in_bypass ? pad_in_gated : in_reg;
            end
        end
    end

    // ==========================================================
    // temporary special pins and test switches
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            diag_shift_reg <= '0;
            diagnostic_clock_pin_prev_reg  <= 1'b0;
            probe_a_reg    <= 1'b0;
            probe_b_reg    <= 1'b0;
            diag_user_reg  <= '0;
            track_pass_reg <= 1'b0;
        end else begin
            diagnostic_clock_pin_prev_reg <= diagnostic_clock_pin;
            if (diag_mode && diagnostic_clock_pin && !diagnostic_clock_pin_prev_reg) begin
                diag_shift_reg <= {diag_shift_reg[DIAG_SHIFT_W-2:0],
                                   serial_program_input};
            end
            probe_a_reg    <= diag_mode ? sm_q_reg : user_probe_a;
            probe_b_reg    <= diag_mode ? pad_y_reg : user_probe_b;
            diag_user_reg  <= diag_mode ? 2'h0
                                        : {diagnostic_clock_pin, serial_program_input};
            track_pass_reg <= diag_mode & pad_cfg_reg.track_test;
        end
    end

    // ==========================================================
    // outputs straight from flip-flops
    assign reg_rdata         = rdata_reg;
    assign cm_y              = cm_y_reg;
    assign sm_q              = sm_q_reg;
    assign routed_clock_zero = routed_reg[0];
    assign routed_clock_one  = routed_reg[1];
    assign perm_pin_user_in  = perm_user_reg;
    assign pad_drv           = pad_drv_reg;
    assign pad_y             = pad_y_reg;
    assign probe_output_a    = probe_a_reg;
    assign probe_output_b    = probe_b_reg;
    assign diag_pin_user_in  = diag_user_reg;
    assign track_pass_on     = track_pass_reg;

    // ==========================================================
    // checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_cmod_mux_sel: assert property (
        ##1 cm_y == $past(cm_in.data[{cm_in.or_term_first | cm_in.or_term_second,
                                      cm_in.and_term_first & cm_in.and_term_second}]))
        else $error("c-cell output does not follow its select terms");

    a_sm_clear_zero: assert property (storage_clear |=> !sm_q)
        else $error("clear did not zero the stored bit");

    a_sm_ff_hold: assert property (
        (!logic_cfg_reg.latch_mode && !s_edge && !storage_clear) |=> $stable(sm_q))
        else $error("flip-flop changed without a rising edge");

    a_sm_ff_capture: assert property (
        (!logic_cfg_reg.latch_mode && s_edge && !storage_clear)
        |=> sm_q == $past(c_mux(sm_in)))
        else $error("flip-flop missed its mux value on the edge");

    a_sclk_route_one: assert property (
        (logic_cfg_reg.clk_sel == SCLK_ROUTED1 && $stable(logic_cfg_reg.clk_sel)
         && !logic_cfg_reg.latch_mode && !storage_clear && $rose(routed_reg[1]))
        |=> sm_q == $past(c_mux(sm_in)))
        else $error("s-cell missed a rising edge of routed net one");

    a_io_set_reset: assert property (
        pcl_eff |=> out_reg == $past(pad_cfg_reg.preset_sel)
                    && in_reg == $past(pad_cfg_reg.preset_sel))
        else $error("set/reset net did not force the pad registers");

    a_io_enable_hold: assert property (
        (!pcl_eff && !output_register_load_enable) |=> $stable(out_reg))
        else $error("output register loaded without its enable");

    a_track_pass_off: assert property (!diag_mode |=> !track_pass_on)
        else $error("track switches on outside test mode");

    a_pad_test_drive: assert property (
        diag_mode |=> pad_drv.oe_n == !$past(global_pad_drive_enable))
        else $error("test mode drive enable not applied to the pad");

    a_role_locked: assert property (
        role_cfg_reg.lock |=> $stable(role_cfg_reg))
        else $error("locked pin roles changed");

endmodule

//--- lcf_user_logic.sv
// user logic model standing in the routing fabric
`timescale 1ns/10ps
module lcf_user_logic
    import lcf_pkg::*;
(
    ref_clk,       // fabric clock
    nrst,          // async reset, low
    cmd,           // wanted routing levels
    cm_in,         // c-cell drive
    sm_in,         // s-cell drive
    storage_clear  // s-cell clear
);
    input  wire logic        ref_clk;
    input  wire logic        nrst;
    input  wire logic [16:0] cmd;
    output lcf_cmod_in_t     cm_in;
    output lcf_cmod_in_t     sm_in;
    output logic             storage_clear;
    // registered drive, so every change lands one edge after the request
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            {cm_in, sm_in, storage_clear} <= '0;
        else
            {cm_in, sm_in, storage_clear} <= cmd;
    end
endmodule

//--- lcf_fabric_bench.sv
// self-checking bench for the logic, pad and clock fabric
`timescale 1ns/10ps
module lcf_fabric_bench;
    import lcf_pkg::*;
    typedef struct {int cyc; int id; logic [31:0] exp;} lcf_note_t;
    logic               ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
    logic [ADDR_W-1:0]  reg_addr = '0;
    logic [DATA_W-1:0]  reg_wdata = '0, reg_rdata;
    logic [20:0]        v = '0;
    logic [16:0]        cmd = '0;
    logic [7:0]         r;
    logic [20:0]        w;
    wire  [13:0]        o;
    logic [1:0]         diag_pin_user_in;
    logic               cm_y, sm_q, track_pass_on, storage_clear;
    lcf_cmod_in_t       cm_in, sm_in;
    int                 cyc = 0, errors = 0, n_tests = 0;
    lcf_note_t          q[$];
    lcf_note_t          nt;
    // ==========================================================
    // design and partner
    lcf_user_logic lcf_user_logic_i (.ref_clk, .nrst, .cmd, .cm_in, .sm_in, .storage_clear);
    lcf_fabric lcf_fabric_i (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cm_in, .sm_in, .storage_clear, .cm_y, .sm_q,
        .external_clock_pad_a(v[3]), .external_clock_pad_b(v[4]),
        .internal_clock_source_a(v[5]), .internal_clock_source_b(v[6]),
        .hard_array_clock(v[7]), .dedicated_pad_register_clock(v[8]),
        .pad_register_set_reset_net(v[9]), .routed_clock_zero(o[0]), .routed_clock_one(o[1]),
        .perm_pin_user_in(o[6:2]), .upper_channel_input(v[10]), .lower_channel_input(v[11]),
        .output_register_load_enable(v[12]), .input_register_load_enable(v[13]),
        .pad_drive_request(v[14]), .pad_receive_enable(v[15]), .pad_in(v[16]),
        .pad_drv(o[10:7]), .pad_y(o[11]), .diag_mode(v[0]), .global_pad_drive_enable(v[17]),
        .global_pad_receive_enable(v[18]), .slew_select(v[19]),
        .diagnostic_clock_pin(v[1]), .serial_program_input(v[2]), .user_probe_a(v[20]),
        .user_probe_b(v[3]), .probe_output_a(o[12]), .probe_output_b(o[13]), .diag_pin_user_in,
        .track_pass_on);
    // ==========================================================
    // clock, bus tasks, scoreboard
    always #4 ref_clk = ~ref_clk;
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        errors += q.size(); // notes never compared
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic put(int lat, int id, logic [31:0] exp);
        q.push_back('{cyc + lat, id, exp});
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] exp);
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        put(2, 0, exp);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    // watcher: every note due this cycle is compared, hang limit kept here
    always @(negedge ref_clk) begin
        cyc++;
        if (cyc > 2000) begin
            errors++;
            end_sim();
        end
        while (q.size() > 0 && q[0].cyc == cyc) begin
            nt = q.pop_front();
            case (nt.id)
                0: chk(reg_rdata, nt.exp);
                1: chk({31'h0, cm_y}, nt.exp);
                2: chk({31'h0, sm_q}, nt.exp);
                3: chk({31'h0, track_pass_on}, nt.exp);
                5: chk({18'h0, o}, nt.exp);
                default: chk({30'h0, diag_pin_user_in}, nt.exp);
            endcase
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(56392));
        v <= 21'($urandom) & 21'h1FFFF8;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        wr(OFS_LOGIC_CFG, 32'h0000_0007);
        rd(OFS_LOGIC_CFG, 32'h0000_0007);
        rd(8'h40, 32'h0);
        $display("register test done");
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            r = {4'($urandom), i[3:0]};
            cmd <= {r, 8'h00, 1'b0};
            put(3, 1, {31'h0, r[4 + {r[1] | r[0], r[3] & r[2]}]});
        end
        repeat (4) @(posedge ref_clk);
        $display("c-cell test done");
        v[5] <= 1'b0;
        wr(OFS_NET_CFG, 32'h0000_0008);
        wr(OFS_LOGIC_CFG, 32'h0000_0002);
        v[5] <= 1'b1;
        cmd <= {8'h00, 8'hF0, 1'b0};
        put(4, 2, 32'h1);
        repeat (4) @(posedge ref_clk);
        cmd <= {8'h00, 8'hFF, 1'b1};
        put(4, 2, 32'h0);
        repeat (6) @(posedge ref_clk);
        $display("clear test done");
        wr(OFS_PAD_CFG, 32'h0000_0040);
        for (int k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            w = {18'($urandom), k[2:0]};
            v <= w;
            put(2, 3, {31'h0, k[0]});
            put(2, 4, k[0] ? 32'h0 : {30'h0, k[1], k[2]});
            put(2, 5, {18'h0, (k[0] ? 2'b00 : {w[3], w[20]}), 2'b00,
                       (k[0] ? {~w[17], w[18], w[19]} : {~w[14], w[15], 1'b0}),
                       w[9], w[8], w[7], w[4], w[3], w[5], 1'b0});
        end
        repeat (4) @(posedge ref_clk);
        $display("diagnostic pin test done");
        end_sim();
    end
endmodule
